/* File: hdl/hes_pkg.sv */
// Purpose: Shared constants, types and functions of the EDC slice
// Assumes: 16-bit slice, Hsiao-style odd-weight code over 6 check bits
// Notes:   Each latch is a clock-enabled register
package hes_pkg;

  // Word and check-bit widths
  localparam int DATA_W     = 16;
  localparam int CB_IN_W    = 7;
  localparam int CB_W_16    = 6;
  localparam int CB_W_32    = 7;
  localparam int CB_W_64    = 8;
  localparam int BYTE_W     = 8;

  // Diagnostic latch layout: check byte low, control byte high
  localparam int DIAG_CB_LSB      = 0;
  localparam int CTL_DETECT_BIT   = 8;
  localparam int CTL_CORRECT_BIT  = 9;
  localparam int CTL_DIAG_BIT     = 10;
  localparam logic [15:0] DIAG_RST = 16'h0000;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DIAG   = 8'h08;
  localparam int         CTRL_INT_BIT = 0;
  localparam int         ST_ERR_BIT   = 7;
  localparam int         ST_MULT_BIT  = 8;
  localparam int         ST_MODE_LSB  = 12;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;

  // Operating modes
  typedef enum logic [2:0] {
    HES_GEN,
    HES_DETECT,
    HES_CORRECT,
    HES_DIAG_DETECT,
    HES_DIAG_CORRECT
  } hes_mode_e;

  // Code column of each data bit (distinct, weight three)
  function automatic logic [CB_W_16-1:0] hes_col(input int idx);
    logic [CB_W_16-1:0] c;
    c = 6'h00;
    case (idx)
      0:  c = 6'h07;
      1:  c = 6'h0B;
      2:  c = 6'h0D;
      3:  c = 6'h0E;
      4:  c = 6'h13;
      5:  c = 6'h15;
      6:  c = 6'h16;
      7:  c = 6'h19;
      8:  c = 6'h1A;
      9:  c = 6'h1C;
      10: c = 6'h23;
      11: c = 6'h25;
      12: c = 6'h26;
      13: c = 6'h29;
      14: c = 6'h2A;
      15: c = 6'h2C;
      default: c = 6'h00;
    endcase
    return c;
  endfunction : hes_col

  // Mode from detect, correct and diagnostic selects
  function automatic hes_mode_e hes_mode_f(input logic det, input logic cor,
                                           input logic dia);
    hes_mode_e m;
    m = HES_GEN;
    if (det)
    begin
      if (dia)
        m = cor ? HES_DIAG_CORRECT : HES_DIAG_DETECT;
      else
        m = cor ? HES_CORRECT : HES_DETECT;
    end
    return m;
  endfunction : hes_mode_f

endpackage : hes_pkg

/* File: hdl/hes_checkgen.sv */
// Purpose: Check-bit generator over one 16-bit data word
// Assumes: Combinational, fed from the input data latch
// Notes:   Check bit j is the parity of the data bits whose column has bit j
`timescale 1ns/10ps
module hes_checkgen
  import hes_pkg::*;
(
  input  wire logic [hes_pkg::DATA_W-1:0]  data_in,
  output logic      [hes_pkg::CB_W_16-1:0] check_out
);

  // Parity tree per check bit
  always_comb
  begin
    check_out = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      if (data_in[i])
        check_out = check_out ^ hes_col(i);
    end
  end

endmodule : hes_checkgen

/* File: hdl/hes_corrector.sv */
// Purpose: Syndrome decode and single data-bit correction
// Assumes: Syndrome is stored XOR regenerated check bits
// Notes:   Check-bit errors flag but leave data unchanged
`timescale 1ns/10ps
module hes_corrector
  import hes_pkg::*;
(
  input  wire logic [hes_pkg::CB_W_16-1:0] syndrome,
  input  wire logic [hes_pkg::DATA_W-1:0]  data_in,
  output logic      [hes_pkg::DATA_W-1:0]  data_fix,
  output logic                             any_err,
  output logic                             multi_err,
  output logic                             data_single
);

  // Locate the bit whose column equals the syndrome
  always_comb
  begin
    data_fix    = data_in;
    data_single = 1'b0;
    any_err     = |syndrome;
    for (int i = 0; i < DATA_W; i++)
    begin
      if (syndrome == hes_col(i))
      begin
        data_fix[i] = ~data_in[i];
        data_single = 1'b1;
      end
    end
    // Even weight or unmatched odd weight above one means several errors
    multi_err = any_err && !data_single && ($countones(syndrome) != 1);
  end

endmodule : hes_corrector

/* File: hdl/hes_slice.sv */
// Purpose: 16-bit Hamming error detection and correction slice
// Assumes: All pin inputs synchronous to sys_clk; APB slave with no wait
// Notes:   Latches are modelled as enable-gated registers
`timescale 1ns/10ps
module hes_slice
  import hes_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic                         clk_en,
  input  wire logic [hes_pkg::DATA_W-1:0]   data_i,
  output logic      [hes_pkg::DATA_W-1:0]   data_o,
  output logic      [hes_pkg::DATA_W-1:0]   data_oe,
  input  wire logic [hes_pkg::CB_IN_W-1:0]  cb_i,
  input  wire logic                         input_capture_enable,
  input  wire logic                         result_capture_enable,
  input  wire logic                         diag_capture_enable,
  input  wire logic                         bypass_to_result,
  input  wire logic                         detect_sel,
  input  wire logic                         correct_sel,
  input  wire logic                         diag_sel,
  input  wire logic [1:0]                   byte_out_en,
  output logic      [hes_pkg::CB_IN_W-1:0]  sc_o,
  output logic                              error_n,
  output logic                              mult_error_n,
  input  wire logic [7:0]                   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr
);

  logic [DATA_W-1:0]  in_data_ff;
  logic [CB_IN_W-1:0] in_cb_ff;
  logic [DATA_W-1:0]  diag_ff;
  logic [DATA_W-1:0]  out_ff;
  logic [CB_IN_W-1:0] sc_ff;
  logic               err_n_ff;
  logic               mult_n_ff;
  logic [31:0]        ctrl_ff;
  logic [31:0]        prdata_ff;
  logic [CB_W_16-1:0] gen_cb;
  logic [CB_W_16-1:0] used_cb;
  logic [CB_W_16-1:0] syndrome;
  logic [DATA_W-1:0]  fixed_data;
  logic               any_err;
  logic               multi_err;
  logic               data_single;
  logic               internal_mode;
  logic               chk_mode;
  logic               cor_mode;
  logic               diag_cb_mode;
  logic [DATA_W-1:0]  nxt_out;
  logic [CB_IN_W-1:0] nxt_sc;
  logic [31:0]        nxt_rdata;
  logic               apb_setup;
  logic               apb_access;
  logic               addr_hit;
  hes_mode_e          mode;

  // Input data and check-bit latches
  // Follow while enabled
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      in_data_ff <= '0;
      in_cb_ff   <= '0;
    end
    else if (clk_en && input_capture_enable)
    begin
      in_data_ff <= data_i;
      in_cb_ff   <= cb_i;
    end
  end

  // Diagnostic latch
  // Load from data lines
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      diag_ff <= DIAG_RST;
    else if (clk_en && diag_capture_enable)
      diag_ff <= data_i;
  end

  // Mode source: pins, or control byte in internal mode
  // Select control source
  always_comb
  begin
    internal_mode = ctrl_ff[CTRL_INT_BIT];
    if (internal_mode)
      mode = hes_mode_f(diag_ff[CTL_DETECT_BIT], diag_ff[CTL_CORRECT_BIT],
                        diag_ff[CTL_DIAG_BIT]);
    else
      mode = hes_mode_f(detect_sel, correct_sel, diag_sel);
  end

  // Mode decode into datapath controls
  // Generation versus detect/correct
  always_comb
  begin
    chk_mode     = (mode != HES_GEN);
    cor_mode     = (mode == HES_CORRECT) || (mode == HES_DIAG_CORRECT);
    diag_cb_mode = (mode == HES_DIAG_DETECT) || (mode == HES_DIAG_CORRECT);
  end

  // Check-bit generator
  // Six bits over sixteen
  hes_checkgen u_gen (
    .data_in   (in_data_ff),
    .check_out (gen_cb)
  );

  // Stored check bits, forced from diagnostic byte in diagnostic modes
  // Diagnostic check bits
  always_comb
  begin
    if (diag_cb_mode)
      used_cb = diag_ff[DIAG_CB_LSB +: CB_W_16];
    else
      used_cb = in_cb_ff[CB_W_16-1:0];
  end

  assign syndrome = gen_cb ^ used_cb;

  // Syndrome decode and correction
  // Decode and flip
  hes_corrector u_fix (
    .syndrome    (syndrome),
    .data_in     (in_data_ff),
    .data_fix    (fixed_data),
    .any_err     (any_err),
    .multi_err   (multi_err),
    .data_single (data_single)
  );

  // Syndrome or generated check bits for the dedicated outputs
  // Syndrome, never corrected bits
  always_comb
  begin
    nxt_sc = '0;
    if (chk_mode)
      nxt_sc[CB_W_16-1:0] = syndrome;
    else
      nxt_sc[CB_W_16-1:0] = gen_cb;
  end

  // Registered syndrome and error flags
  // Active-low flags
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sc_ff     <= '0;
      err_n_ff  <= 1'b1;
      mult_n_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      sc_ff     <= nxt_sc;
      err_n_ff  <= !(chk_mode && any_err);
      mult_n_ff <= !(chk_mode && multi_err);
    end
  end

  // Result source: bypass, corrected, or raw word
  // Choose result source
  always_comb
  begin
    if (bypass_to_result || !cor_mode)
      nxt_out = in_data_ff;
    else
      nxt_out = fixed_data;
  end

  // Result latch
  // Load on enable
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      out_ff <= '0;
    else if (clk_en && (result_capture_enable || bypass_to_result))
      out_ff <= nxt_out;
  end

  // Byte-wise drive of the data lines
  // Independent byte enables
  assign data_o  = out_ff;
  assign data_oe = {{BYTE_W{byte_out_en[1]}}, {BYTE_W{byte_out_en[0]}}};
  assign sc_o         = sc_ff;
  assign error_n      = err_n_ff;
  assign mult_error_n = mult_n_ff;

  // APB phase and address decode
  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign addr_hit   = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                      (paddr == ADDR_DIAG);
  assign pready     = 1'b1;
  assign pslverr    = apb_access && !addr_hit;
  assign prdata     = prdata_ff;

  // Control register write
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      ctrl_ff <= CTRL_RST;
    else if (apb_access && pwrite && (paddr == ADDR_CTRL))
      ctrl_ff <= {31'h0000_0000, pwdata[CTRL_INT_BIT]};
  end

  // Read mux
  always_comb
  begin
    nxt_rdata = '0;
    unique case (paddr)
      ADDR_CTRL:   nxt_rdata = ctrl_ff;
      ADDR_STATUS:
      begin
        nxt_rdata[CB_IN_W-1:0]           = sc_ff;
        nxt_rdata[ST_ERR_BIT]            = !err_n_ff;
        nxt_rdata[ST_MULT_BIT]           = !mult_n_ff;
        nxt_rdata[ST_MODE_LSB +: 3]      = mode;
      end
      ADDR_DIAG:   nxt_rdata[DATA_W-1:0] = diag_ff;
      default:     nxt_rdata = '0;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      prdata_ff <= '0;
    else if (apb_setup && !pwrite)
      prdata_ff <= nxt_rdata;
  end

  // Checks
  default clocking cb_def @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_in_load;
    clk_en && input_capture_enable |=> in_data_ff == $past(data_i);
  endproperty
  a_in_load: assert property (p_in_load) else $error("input latch missed");

  property p_cb_load;
    clk_en && input_capture_enable |=> in_cb_ff == $past(cb_i);
  endproperty
  a_cb_load: assert property (p_cb_load) else $error("check latch missed");

  property p_hold;
    !(clk_en && input_capture_enable) |=> $stable(in_data_ff) && $stable(in_cb_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("input latch moved");

  property p_syn;
    clk_en && chk_mode |=> sc_o[CB_W_16-1:0] == ($past(gen_cb) ^ $past(used_cb));
  endproperty
  a_syn: assert property (p_syn) else $error("syndrome wrong");

  property p_noerr;
    clk_en && chk_mode && (syndrome == '0) |=> error_n && mult_error_n && sc_o == '0;
  endproperty
  a_noerr: assert property (p_noerr) else $error("false error flag");

  property p_err;
    clk_en && chk_mode && (syndrome != '0) |=> !error_n;
  endproperty
  a_err: assert property (p_err) else $error("error flag missing");

  property p_mult;
    clk_en && chk_mode && (syndrome != '0) && !(^syndrome) |=> !error_n && !mult_error_n;
  endproperty
  a_mult: assert property (p_mult) else $error("multi flag missing");

  property p_fix;
    clk_en && result_capture_enable && !bypass_to_result && cor_mode && data_single
      |=> $countones(data_o ^ $past(in_data_ff)) == 1;
  endproperty
  a_fix: assert property (p_fix) else $error("correction not one bit");

  property p_bypass;
    clk_en && bypass_to_result |=> data_o == $past(in_data_ff);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");

  property p_diag;
    clk_en && diag_capture_enable |=> diag_ff == $past(data_i);
  endproperty
  a_diag: assert property (p_diag) else $error("diag latch missed");

  property p_gen;
    clk_en && !chk_mode |=> error_n && sc_o[CB_W_16-1:0] == $past(gen_cb);
  endproperty
  a_gen: assert property (p_gen) else $error("generate output wrong");

  // Check byte of the diagnostic latch, for the a_diag_cb check below
  logic [CB_W_16-1:0] diag_cb;
  assign diag_cb = diag_ff[DIAG_CB_LSB +: CB_W_16];

  property p_freeze;
    !clk_en |=> $stable(in_data_ff) && $stable(out_ff) && $stable(sc_ff) && $stable(diag_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_cb_single;
    clk_en && cor_mode && ($countones(syndrome) == 1) && result_capture_enable &&
      !bypass_to_result |=> data_o == $past(in_data_ff);
  endproperty
  a_cb_single: assert property (p_cb_single) else $error("check error moved data");

  property p_diag_cb;
    clk_en && diag_cb_mode |=> sc_o[CB_W_16-1:0] == ($past(gen_cb) ^ $past(diag_cb));
  endproperty
  a_diag_cb: assert property (p_diag_cb) else $error("diag check bits unused");

  property p_clean_out;
    clk_en && result_capture_enable && !bypass_to_result && !any_err
      |=> data_o == $past(in_data_ff);
  endproperty
  a_clean_out: assert property (p_clean_out) else $error("clean word altered");

endmodule : hes_slice

/* File: verif/hes_mem_model.sv */
// Purpose: Memory word and check-bit array on the far side of the slice
// Assumes: One write port, combinational read with commanded bit flips
// Notes:   Idle read lines show the inverted word, never the last value
`timescale 1ns/10ps
module hes_mem_model
  import hes_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        we,
  input  wire logic                        rd_en,
  input  wire logic [3:0]                  addr,
  input  wire logic [hes_pkg::DATA_W-1:0]  wdata,
  input  wire logic [hes_pkg::CB_W_16-1:0] wcb,
  input  wire logic [hes_pkg::DATA_W-1:0]  dflip,
  input  wire logic [hes_pkg::CB_W_16-1:0] cflip,
  output logic      [hes_pkg::DATA_W-1:0]  rdata,
  output logic      [hes_pkg::CB_W_16-1:0] rcb
);
  logic [21:0] mem_ff [16];

  // Cleared array, then word store
  initial
    foreach (mem_ff[i])
      mem_ff[i] = 22'h00_0000;
  always @(posedge clk)
    if (we)
      mem_ff[addr] <= {wcb, wdata};

  // Read with injected faults
  assign {rcb, rdata} = rd_en ? (mem_ff[addr] ^ {cflip, dflip}) : ~mem_ff[addr];
endmodule : hes_mem_model

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench of the EDC slice
// Assumes: Pin datapath as in hand-over, APB zero wait
// Notes:   Check-bit columns kept locally, not taken from the design
`timescale 1ns/10ps
module tb_top;
  import hes_pkg::*;
  localparam logic [5:0] COL [16] = '{6'h07, 6'h0B, 6'h0D, 6'h0E, 6'h13, 6'h15, 6'h16,
    6'h19, 6'h1A, 6'h1C, 6'h23, 6'h25, 6'h26, 6'h29, 6'h2A, 6'h2C};
  logic        sys_clk, nrst, clk_en, ice, rce, dce, byp, det, cor, dia;
  logic        mem_we, rd_en, psel, penable, pwrite, error_n, mult_n, pready, pslverr, err;
  logic [1:0]  boe;
  logic [3:0]  m_addr;
  logic [15:0] bus_d, m_wd, dflip, m_rd, data_i, data_o, data_oe, d;
  logic [5:0]  m_wcb, cflip, m_rcb;
  logic [6:0]  sc_o;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          err_total, checks_done, cyc;

  assign data_i = rd_en ? m_rd : bus_d;

  hes_mem_model u_mem (.clk(sys_clk), .we(mem_we), .rd_en(rd_en), .addr(m_addr), .wdata(m_wd),
    .wcb(m_wcb), .dflip(dflip), .cflip(cflip), .rdata(m_rd), .rcb(m_rcb));

  hes_slice u_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .data_i(data_i),
    .data_o(data_o), .data_oe(data_oe), .cb_i({1'b0, m_rcb}), .input_capture_enable(ice),
    .result_capture_enable(rce), .diag_capture_enable(dce), .bypass_to_result(byp),
    .detect_sel(det), .correct_sel(cor), .diag_sel(dia), .byte_out_en(boe), .sc_o(sc_o),
    .error_n(error_n), .mult_error_n(mult_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Clock source
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      test_done();
    end
  end

  function automatic logic [5:0] gen_cb(input logic [15:0] w);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 16; i++)
      if (w[i])
        c = c ^ COL[i];
    return c;
  endfunction : gen_cb

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_mode(input logic a, input logic b, input logic c);
    @(posedge sys_clk);
    det <= a;
    cor <= b;
    dia <= c;
  endtask : set_mode

  // Store word, read it back with faults, capture result
  task automatic op(input logic [15:0] df, input logic [5:0] cf, input logic bp);
    @(posedge sys_clk);
    mem_we <= 1'b1;
    m_addr <= d[3:0];
    m_wd <= d;
    m_wcb <= gen_cb(d);
    @(posedge sys_clk);
    mem_we <= 1'b0;
    rd_en <= 1'b1;
    dflip <= df;
    cflip <= cf;
    ice <= 1'b1;
    byp <= bp;
    @(posedge sys_clk);
    ice <= 1'b0;
    rd_en <= 1'b0;
    rce <= !bp;
    @(posedge sys_clk);
    rce <= 1'b0;
    byp <= 1'b0;
    @(negedge sys_clk);
  endtask : op

  // Main sequence
  initial
  begin
    {nrst, ice, rce, dce, byp, det, cor, dia, mem_we, rd_en, psel, penable, pwrite} = '0;
    {boe, m_addr, bus_d, m_wd, dflip, m_wcb, cflip, paddr, pwdata} = '0;
    clk_en = 1'b1;
    d = 16'hA5C3;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk({sc_o, error_n, mult_n, data_o}, {7'h00, 2'b11, 16'h0000});
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    set_mode(1'b0, 1'b0, 1'b0);
    op(16'h0000, 6'h00, 1'b0);
    chk(sc_o, gen_cb(d));
    set_mode(1'b1, 1'b1, 1'b0);
    op(16'h0000, 6'h00, 1'b0);
    chk({sc_o, error_n, mult_n, data_o}, {7'h00, 2'b11, d});
    for (int i = 0; i < 16; i++)
    begin
      op(16'h0001 << i, 6'h00, 1'b0);
      chk({sc_o, error_n, mult_n}, {1'b0, COL[i], 2'b01});
      chk(data_o, d);
    end
    for (int j = 0; j < 6; j++)
    begin
      op(16'h0000, 6'h01 << j, 1'b0);
      chk({sc_o, error_n, mult_n, data_o}, {7'h01 << j, 2'b01, d});
    end
    op(16'h0003, 6'h00, 1'b0);
    chk({sc_o, error_n, mult_n}, {1'b0, COL[0] ^ COL[1], 2'b00});
    set_mode(1'b0, 1'b0, 1'b0);
    op(16'h0000, 6'h01, 1'b0);
    chk(sc_o, gen_cb(d));
    set_mode(1'b1, 1'b0, 1'b0);
    op(16'h0010, 6'h00, 1'b0);
    chk({error_n, mult_n, data_o}, {2'b01, d ^ 16'h0010});
    set_mode(1'b1, 1'b1, 1'b0);
    op(16'h0100, 6'h00, 1'b1);
    chk(data_o, d ^ 16'h0100);
    // Clock enable low must block an input latch load
    @(posedge sys_clk);
    clk_en <= 1'b0;
    ice <= 1'b1;
    @(posedge sys_clk);
    clk_en <= 1'b1;
    ice <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(sc_o, COL[8]);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk);
      boe <= k[1:0];
      @(negedge sys_clk);
      chk(data_oe, {{8{k[1]}}, {8{k[0]}}});
    end
    // Diagnostic word: control byte selects diag correct, check byte is clean
    @(posedge sys_clk);
    bus_d <= {8'h07, 2'b00, gen_cb(d)};
    dce <= 1'b1;
    @(posedge sys_clk);
    dce <= 1'b0;
    apb(1'b0, ADDR_DIAG, 32'h0000_0000);
    chk(rd, {16'h0000, 8'h07, 2'b00, gen_cb(d)});
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    set_mode(1'b0, 1'b0, 1'b0);
    op(16'h0020, 6'h3F, 1'b0);
    chk({sc_o, error_n, mult_n, data_o}, {1'b0, COL[5], 2'b01, d});
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rd[14:12], 3'h4);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(err, 1'b1);
    test_done();
  end
endmodule : tb_top
